// ==== lsdr_lut_cell.sv ====
`timescale 1ns/10ps
module lsdr_lut_cell
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Configuration
	input wire lsdr_pkg::lsdr_shape_e shape,
	input wire logic write_enable,
	// Shift mode
	input wire logic serial_data_in,
	input wire logic [lsdr_pkg::LSDR_TAP_WIDTH-1:0] tap_address,
	output logic tap_out,
	output logic cascade_tail_out,
	// Memory mode addresses and data
	input wire logic [lsdr_pkg::LSDR_ADDR_WIDTH-1:0] rw_address,
	input wire logic [lsdr_pkg::LSDR_ADDR_WIDTH-1:0] read_only_address,
	input wire logic [lsdr_pkg::LSDR_ADDR_WIDTH-1:0] quad_read_address_b,
	input wire logic [lsdr_pkg::LSDR_ADDR_WIDTH-1:0] quad_read_address_c,
	input wire logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] ram_data_in,
	output logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] rw_data_out,
	output logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] read_data_out_a,
	output logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] read_data_out_b,
	output logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] read_data_out_c,
	// Stream of bits leaving position 31
	output logic tail_valid,
	output logic tail_data,
	input wire logic tail_ready,
	output logic shift_ready
);
	import lsdr_pkg::*;

	logic [LSDR_SHIFT_DEPTH-1:0] shift_reg;
	logic mem_reg [LSDR_MEM_BITS];
	logic shift_wanted;
	logic shift_go;
	logic ram_write;
	logic [LSDR_ADDR_WIDTH-1:0] wr_index;

	lsdr_stream_if #(.WIDTH(1)) fill_if ();
	lsdr_stream_if #(.WIDTH(1)) drain_if ();

	// ------------------------------------------------------------
	// Shape decoding
	// ------------------------------------------------------------
	// True for the 32-entry shapes, which store two bits per word.
	function automatic logic is_wide(input lsdr_shape_e s);
		is_wide = (s == LSDR_SP32) || (s == LSDR_DP32) || (s == LSDR_QP32);
	endfunction

	// Address lines in use for a shape; upper lines are ignored.
	function automatic logic [7:0] addr_mask(input lsdr_shape_e s);
		unique case (s)
			LSDR_SP32, LSDR_DP32, LSDR_QP32: addr_mask = LSDR_MASK_32;
			LSDR_SP64, LSDR_DP64, LSDR_QP64: addr_mask = LSDR_MASK_64;
			LSDR_SP128, LSDR_DP128: addr_mask = LSDR_MASK_128;
			LSDR_SP256: addr_mask = LSDR_MASK_256;
			default: addr_mask = 8'h00;
		endcase
	endfunction

	// Number of read-only ports: 0 single, 1 dual, 3 quad.
	function automatic logic [1:0] ro_ports(input lsdr_shape_e s);
		unique case (s)
			LSDR_DP32, LSDR_DP64, LSDR_DP128: ro_ports = 2'h1;
			LSDR_QP32, LSDR_QP64: ro_ports = 2'h3;
			default: ro_ports = 2'h0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Combinational reads
	// ------------------------------------------------------------
	// A wide word sits in two neighbouring cells; a narrow one in the low lane.
	function automatic logic [1:0] read_word(input lsdr_shape_e s, input logic [7:0] a);
		logic [7:0] m;
		m = a & addr_mask(s);
		if (s == LSDR_SHIFT)
			read_word = 2'h0;
		else if (is_wide(s))
			read_word = {mem_reg[{m[6:0], 1'b1}], mem_reg[{m[6:0], 1'b0}]};
		else
			read_word = {1'b0, mem_reg[m]};
	endfunction

	// Reads bypass the clock so an address change shows without waiting for an edge.
	// The read outputs are therefore not registered; a flop here would break the timing model.
	always_comb
	begin
		rw_data_out = read_word(shape, rw_address);
		read_data_out_a = 2'h0;
		read_data_out_b = 2'h0;
		read_data_out_c = 2'h0;
		if (ro_ports(shape) != 2'h0)
			read_data_out_a = read_word(shape, read_only_address);
		if (ro_ports(shape) == 2'h3)
		begin
			read_data_out_b = read_word(shape, quad_read_address_b);
			read_data_out_c = read_word(shape, quad_read_address_c);
		end
	end

	// Tap read: any of the 32 positions, straight from the register.
	assign tap_out = shift_reg[tap_address];

	// Position 31 is a flop, so the cascade output is registered.
	assign cascade_tail_out = shift_reg[LSDR_TAIL_POS];

	// ------------------------------------------------------------
	// Shift path
	// ------------------------------------------------------------
	// The bit pushed out of position 31 is offered to the tail buffer. A full
	// buffer holds the shift off so the receiver never loses a bit.
	assign shift_wanted = write_enable && (shape == LSDR_SHIFT);
	assign shift_go = shift_wanted && fill_if.ready;
	assign fill_if.valid = shift_wanted;
	assign fill_if.data = shift_reg[LSDR_TAIL_POS];

	// No reset on the storage, so a system reset keeps the pattern.
	always_ff @(posedge clk)
	begin
		if (shift_go)
			shift_reg <= {shift_reg[LSDR_SHIFT_DEPTH-2:0], serial_data_in};
	end

	// ------------------------------------------------------------
	// Memory write path
	// ------------------------------------------------------------
	assign ram_write = write_enable && (shape != LSDR_SHIFT);
	assign wr_index = rw_address & addr_mask(shape);

	// Write port shares its address with the read/write output.
	always_ff @(posedge clk)
	begin
		if (ram_write)
		begin
			if (is_wide(shape))
			begin
				mem_reg[{wr_index[6:0], 1'b0}] <= ram_data_in[0];
				mem_reg[{wr_index[6:0], 1'b1}] <= ram_data_in[1];
			end
			else
				mem_reg[wr_index] <= ram_data_in[0];
		end
	end

	// ------------------------------------------------------------
	// Tail buffer
	// ------------------------------------------------------------
	lsdr_two_entry_buffer #(.WIDTH(1)) tail_buffer (
		.clk(clk),
		.rst_b(rst_b),
		.fill(fill_if.snk),
		.drain(drain_if.src)
	);

	assign drain_if.ready = tail_ready;
	assign tail_valid = drain_if.valid;
	assign tail_data = drain_if.data;
	assign shift_ready = fill_if.ready;

endmodule

// ==== lsdr_pkg.sv ====
package lsdr_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int LSDR_SHIFT_DEPTH = 32;
	localparam int LSDR_TAP_WIDTH = 5;
	localparam int LSDR_MEM_BITS = 256;
	localparam int LSDR_ADDR_WIDTH = 8;
	localparam int LSDR_WORD_WIDTH = 2;
	localparam int LSDR_TAIL_POS = 31;

	// ------------------------------------------------------------
	// Address masks per depth, one set bit per used address line
	// ------------------------------------------------------------
	localparam logic [7:0] LSDR_MASK_32 = 8'h1f;
	localparam logic [7:0] LSDR_MASK_64 = 8'h3f;
	localparam logic [7:0] LSDR_MASK_128 = 8'h7f;
	localparam logic [7:0] LSDR_MASK_256 = 8'hff;

	// ------------------------------------------------------------
	// Reset values and full level of the tail buffer
	// ------------------------------------------------------------
	localparam logic [1:0] LSDR_BUF_COUNT_RST = 2'h0;
	localparam logic [1:0] LSDR_BUF_COUNT_FULL = 2'h2;
	localparam logic LSDR_BUF_PTR_RST = 1'h0;

	// ------------------------------------------------------------
	// Cell configurations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		LSDR_SHIFT = 4'h0,
		LSDR_SP32 = 4'h1,
		LSDR_DP32 = 4'h2,
		LSDR_QP32 = 4'h3,
		LSDR_SP64 = 4'h4,
		LSDR_DP64 = 4'h5,
		LSDR_QP64 = 4'h6,
		LSDR_SP128 = 4'h7,
		LSDR_DP128 = 4'h8,
		LSDR_SP256 = 4'h9
	} lsdr_shape_e;

endpackage

// ==== lsdr_stream_if.sv ====
`timescale 1ns/10ps
// Valid/ready stream between the cell and its tail buffer.
interface lsdr_stream_if #(parameter int WIDTH = 1) ();
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== lsdr_two_entry_buffer.sv ====
`timescale 1ns/10ps
// Two-entry buffer; a stall on the drain side fills it and then stalls the filler.
module lsdr_two_entry_buffer
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Streams
	lsdr_stream_if.snk fill,
	lsdr_stream_if.src drain
);
	import lsdr_pkg::*;

	logic [WIDTH-1:0] entry_reg [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic valid_reg;
	logic ready_reg;
	logic push;
	logic pop;

	// ------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------
	// Ready and valid come from flops so the top outputs stay registered.
	assign push = fill.valid && ready_reg;
	assign pop = valid_reg && drain.ready;
	assign fill.ready = ready_reg;
	assign drain.valid = valid_reg;
	assign drain.data = entry_reg[rd_ptr_reg];

	// Occupancy after this edge.
	always_comb
	begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 2'h1;
		else if (pop && !push)
			count_next = count_reg - 2'h1;
	end

	// Counter and the flags derived from it.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count_reg <= LSDR_BUF_COUNT_RST;
			valid_reg <= 1'b0;
			ready_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			valid_reg <= count_next != LSDR_BUF_COUNT_RST;
			ready_reg <= count_next != LSDR_BUF_COUNT_FULL;
		end
	end

	// Pointers.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_ptr_reg <= LSDR_BUF_PTR_RST;
			rd_ptr_reg <= LSDR_BUF_PTR_RST;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= !wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= !rd_ptr_reg;
		end
	end

	// Entry storage needs no reset; the flags guard it.
	always_ff @(posedge clk)
	begin
		if (push)
			entry_reg[wr_ptr_reg] <= fill.data;
	end

endmodule

// ==== lsdr_cell_sva.sv ====
`timescale 1ns/10ps
// ----
// Checker on the cell ports
// ----
module lsdr_cell_sva
	import lsdr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control and shift mode
	input wire lsdr_pkg::lsdr_shape_e shape,
	input wire logic write_enable,
	input wire logic serial_data_in,
	input wire logic [lsdr_pkg::LSDR_TAP_WIDTH-1:0] tap_address,
	input wire logic tap_out,
	input wire logic cascade_tail_out,
	input wire logic shift_ready,
	// Memory mode
	input wire logic [lsdr_pkg::LSDR_ADDR_WIDTH-1:0] rw_address,
	input wire logic [lsdr_pkg::LSDR_ADDR_WIDTH-1:0] read_only_address,
	input wire logic [lsdr_pkg::LSDR_ADDR_WIDTH-1:0] quad_read_address_b,
	input wire logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] ram_data_in,
	input wire logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] rw_data_out,
	input wire logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] read_data_out_a,
	input wire logic [lsdr_pkg::LSDR_WORD_WIDTH-1:0] read_data_out_b
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic acc;
	logic wide;
	logic [5:0] shifts_reg = 6'h00;
	// Storage powers up unknown, so position checks wait for a full load.
	assign acc = write_enable && shift_ready && shape == LSDR_SHIFT;
	assign wide = shape inside {LSDR_SP32, LSDR_DP32, LSDR_QP32};
	always_ff @(posedge clk)
	begin
		if (acc && !shifts_reg[5])
			shifts_reg <= shifts_reg + 6'h01;
	end
	chk_shift_load:
	assert property ((acc && tap_address == 5'h00) ##1 (tap_address == 5'h00)
		|-> tap_out == $past(serial_data_in)) else $error("shift did not load position 0");
	chk_shift_move:
	assert property ((shifts_reg[5] && acc && tap_address == 5'h1e) ##1 (tap_address == 5'h1f)
		|-> cascade_tail_out == $past(tap_out)) else $error("bit did not move up");
	chk_shift_hold:
	assert property (shifts_reg[5] && (!write_enable || (shape == LSDR_SHIFT && !shift_ready))
		|=> $stable(cascade_tail_out)) else $error("storage changed without a shift");
	chk_tap_tail:
	assert property (shifts_reg[5] && shape == LSDR_SHIFT && tap_address == 5'h1f
		|-> tap_out == cascade_tail_out) else $error("tap 31 differs from cascade");
	chk_ram_write:
	assert property ((write_enable && shape inside {[LSDR_SP32:LSDR_SP256]})
		##1 ($stable(rw_address) && $stable(shape))
		|-> rw_data_out == ($past(wide) ? $past(ram_data_in) : {1'b0, $past(ram_data_in[0])}))
		else $error("written word not seen");
	chk_dual_read:
	assert property ((write_enable && shape inside {LSDR_DP32, LSDR_DP64, LSDR_DP128})
		|=> read_only_address != rw_address || read_data_out_a == rw_data_out)
		else $error("read-only port disagrees");
	chk_quad_read:
	assert property ((write_enable && shape inside {LSDR_QP32, LSDR_QP64})
		|=> quad_read_address_b != rw_address || read_data_out_b == rw_data_out)
		else $error("quad port b disagrees");
	chk_single_port:
	assert property (shape inside {LSDR_SP32, LSDR_SP64, LSDR_SP128, LSDR_SP256}
		|-> read_data_out_a == 2'h0 && read_data_out_b == 2'h0) else $error("spare port live");
	cover property (acc);
	cover property (shape == LSDR_SHIFT && write_enable && !shift_ready);
	cover property (write_enable && shape == LSDR_QP64);
endmodule
bind lsdr_lut_cell lsdr_cell_sva i_sva (.clk, .rst_b, .shape, .write_enable, .serial_data_in,
	.tap_address, .tap_out, .cascade_tail_out, .shift_ready, .rw_address, .read_only_address,
	.quad_read_address_b, .ram_data_in, .rw_data_out, .read_data_out_a, .read_data_out_b);

// ==== lsdr_tail_sink.sv ====
`timescale 1ns/10ps
// Receiver of the tail stream; stall stops it taking bits so the buffer fills.
module lsdr_tail_sink
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Tail stream
	input wire logic tail_valid,
	input wire logic tail_data,
	output logic tail_ready,
	// Bench control
	input wire logic stall,
	output logic [7:0] taken_reg
);
	// Ready is a plain level, so a stall takes effect at the next edge.
	assign tail_ready = !stall;
	// Count the bits taken.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			taken_reg <= 8'h00;
		else if (tail_valid && tail_ready)
			taken_reg <= taken_reg + 8'h01;
	end
endmodule

// ==== lut_shift_and_dist_ram_bench.sv ====
`timescale 1ns/10ps
module lut_shift_and_dist_ram_bench;
	import lsdr_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	lsdr_shape_e shape = LSDR_SHIFT;
	logic write_enable = 1'b0;
	logic serial_data_in = 1'b0;
	logic stall = 1'b0;
	logic [4:0] tap_address = 5'h00;
	logic [7:0] rw_address = 8'h00;
	logic [7:0] read_only_address = 8'h00;
	logic [7:0] quad_read_address_b = 8'h00;
	logic [7:0] quad_read_address_c = 8'h00;
	logic [1:0] ram_data_in = 2'h0;
	logic tap_out, cascade_tail_out, tail_valid, tail_data, tail_ready, shift_ready;
	logic [1:0] rw_data_out, read_data_out_a, read_data_out_b, read_data_out_c;
	logic [7:0] taken;
	logic [31:0] pattern = 32'h8e3ca5f1;
	int num_errors = 0;
	int num_checks = 0;
	// Free-running 100 MHz clock.
	always #5 clk = !clk;
	lsdr_lut_cell i_dut (.clk, .rst_b, .shape, .write_enable, .serial_data_in, .tap_address,
		.tap_out, .cascade_tail_out, .rw_address, .read_only_address, .quad_read_address_b,
		.quad_read_address_c, .ram_data_in, .rw_data_out, .read_data_out_a, .read_data_out_b,
		.read_data_out_c, .tail_valid, .tail_data, .tail_ready, .shift_ready);
	lsdr_tail_sink i_sink (.clk, .rst_b, .tail_valid, .tail_data, .tail_ready, .stall,
		.taken_reg(taken));
	// ----
	// Helpers
	// ----
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task step();
		@(posedge clk);
		#1;
	endtask
	task set_addr(input logic [7:0] a);
		rw_address = a;
		read_only_address = a;
		quad_read_address_b = a;
		quad_read_address_c = a;
	endtask
	task finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Load 32 bits at tap 0, then read each position with no clock involved.
	task t_shift();
		int i;
		write_enable = 1'b1;
		for (i = 0; i < 32; i++)
		begin
			serial_data_in = pattern[i];
			step();
			check("tap zero", tap_out, pattern[i]);
		end
		check("cascade", cascade_tail_out, pattern[0]);
		write_enable = 1'b0;
		for (i = 0; i < 32; i++)
		begin
			step();
			tap_address = i[4:0];
			#1;
			check("tap read", tap_out, pattern[31-i]);
		end
		check("idle cascade", cascade_tail_out, pattern[0]);
		tap_address = 5'h1e;
		write_enable = 1'b1;
		step();
		tap_address = 5'h1f;
		write_enable = 1'b0;
		check("moved", cascade_tail_out, pattern[1]);
	endtask
	// A stalled receiver fills the buffer until shifts are refused; then drain it.
	task t_stall();
		int n;
		stall = 1'b1;
		write_enable = 1'b1;
		for (n = 0; n < 8 && shift_ready === 1'b1; n++)
			step();
		check("full", {tail_valid, shift_ready}, 2'h2);
		check("tail head", tail_data, pattern[0]);
		if (shift_ready !== 1'b0)
			finish_test();
		stall = 1'b0;
		write_enable = 1'b0;
		for (n = 0; n < 8 && tail_valid === 1'b1; n++)
			step();
		step();
		check("drained", {tail_valid, shift_ready}, 2'h1);
		check("bits taken", taken, 8'h22);
	endtask
	// Every memory shape: two writes, then reads through all ports.
	task t_ram();
		int s;
		int j;
		logic [1:0] w;
		for (s = 1; s < 10; s++)
		begin
			shape = lsdr_shape_e'(s);
			write_enable = 1'b1;
			for (j = 0; j < 2; j++)
			begin
				set_addr({8{j[0]}});
				ram_data_in = s[1:0] ^ {2{j[0]}};
				step();
			end
			write_enable = 1'b0;
			for (j = 0; j < 2; j++)
			begin
				step();
				set_addr({8{j[0]}});
				#1;
				w = s[1:0] ^ {2{j[0]}};
				if (s > 3)
					w = {1'b0, w[0]};
				check("rw port", rw_data_out, w);
				check("port a", read_data_out_a, s inside {2, 3, 5, 6, 8} ? w : 2'h0);
				check("port b", read_data_out_b, s inside {3, 6} ? w : 2'h0);
				check("port c", read_data_out_c, s inside {3, 6} ? w : 2'h0);
			end
		end
	endtask
	// Reset in mid-run leaves both storages alone.
	task t_reset();
		logic c;
		c = cascade_tail_out;
		set_addr(8'h00);
		rst_b = 1'b0;
		step();
		check("ready in reset", shift_ready, 1'b0);
		rst_b = 1'b1;
		step();
		check("ram kept", rw_data_out, 2'h1);
		check("shift kept", cascade_tail_out, c);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		rst_b = 1'b1;
		step();
		t_shift();
		t_stall();
		t_ram();
		t_reset();
		finish_test();
	end
endmodule
